// [encoder_position_counter_map.svh]
// Constant definitions for the encoder position counter.
`ifndef ENCODER_POSITION_COUNTER_MAP_SVH
`define ENCODER_POSITION_COUNTER_MAP_SVH
`define POS_WIDTH     32
`define POS_RESET     32'h0000_0000
`define SYNC_STAGES   2
`endif

// [encoder_position_counter_pkg.sv]
// Types shared by the encoder position counter.
`default_nettype none
package encoder_position_counter_pkg;
    // Decoding mode selected by the user.
    typedef enum logic [1:0]
    {
        MODE_X1       = 2'b00,
        MODE_X2       = 2'b01,
        MODE_X4       = 2'b10,
        MODE_TWO_PULSE = 2'b11
    } decode_mode_t;
endpackage : encoder_position_counter_pkg
`default_nettype wire

// [encoder_position_counter.sv]
// Incremental encoder decoder with signed position counter and index alignment.
`timescale 1ns/1ps
`default_nettype none
`include "encoder_position_counter_map.svh"
// Functional notes
// (RULE_01) Encoder drives A and B in quadrature.
// (RULE_02) X1: count up on A rise, A leading.
// (RULE_03) X1: count down on A fall, B leading.
// (RULE_04) X2: step on both A edges.
// (RULE_05) X4: step on every A and B edge; A and B edges in the same clock are dropped.
// (RULE_06) Two-pulse: A pulse counts up.
// (RULE_07) Two-pulse: B pulse counts down.
// (RULE_08) Selectable A/B phase qualifies index.
// (RULE_09) Qualified index loads reference value.
// (RULE_10) Two-stage sync; one step per clock.
module encoder_position_counter
    import encoder_position_counter_pkg::*;
(
    input  wire logic                    clock_in,        // 10 MHz counter clock.
    input  wire logic                    rst_in,          // Synchronous reset, active high.
    input  wire logic                    chan_a_in,       // Encoder channel A pin.
    input  wire logic                    chan_b_in,       // Encoder channel B pin.
    input  wire logic                    index_in,        // Encoder index pin.
    input  wire decode_mode_t            mode_in,         // Decoding mode.
    input  wire logic                    index_enable_in, // Enables index alignment.
    input  wire logic [1:0]              index_phase_in,  // Required {A,B} levels for index.
    input  wire logic [`POS_WIDTH-1:0]   reload_value_in, // Value loaded on qualified index.
    output logic      [`POS_WIDTH-1:0]   position_out,    // Signed position count.
    output logic                         direction_out,   // High when last motion was reverse.
    output logic                         index_seen_out   // Pulses one cycle on index load.
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers.
    logic [2:0] sync1_r;  // First stage; read only by the second stage.
    logic [2:0] sync2_r;  // Second stage; safe to use.
    logic [2:0] prev_r;   // Previous synchronised value for edge detection.

    // Pins are asynchronous, so each passes two flops before any logic reads it.
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            prev_r  <= 3'h0;
        end
        else
        begin
            sync1_r <= {index_in, chan_b_in, chan_a_in}; // RULE_10
            sync2_r <= sync1_r;                          // RULE_10
            prev_r  <= sync2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge and direction decode.
    logic a_s, b_s, z_s;
    logic a_rise, a_fall, b_rise, b_fall, z_rise;
    logic step_up, step_dn;  // Step requests this cycle.
    logic qualified_index;

    assign a_s    = sync2_r[0];
    assign b_s    = sync2_r[1];
    assign z_s    = sync2_r[2];
    assign a_rise = a_s & ~prev_r[0];
    assign a_fall = ~a_s & prev_r[0];
    assign b_rise = b_s & ~prev_r[1];
    assign b_fall = ~b_s & prev_r[1];
    assign z_rise = z_s & ~prev_r[2];

    // Direction follows which channel leads; the encoder must keep 90 degrees apart.
    always_comb
    begin
        step_up = 1'b0;
        step_dn = 1'b0;
        unique case (mode_in)
            MODE_X1:
            begin
                // A rising with B low means A leads; A falling with B low means B leads.
                step_up = a_rise & ~b_s; // RULE_01 RULE_02
                step_dn = a_fall & ~b_s; // RULE_03
            end
            MODE_X2:
            begin
                step_up = (a_rise & ~b_s) | (a_fall & b_s); // RULE_04
                step_dn = (a_fall & ~b_s) | (a_rise & b_s); // RULE_04
            end
            MODE_X4:
            begin
                // Should both channels move together the edge is ambiguous and is dropped.
                step_up = ((a_rise & ~b_s) | (a_fall & b_s) | (b_rise & a_s) | (b_fall & ~a_s))
                          & ~((a_rise | a_fall) & (b_rise | b_fall)); // RULE_05
                step_dn = ((a_fall & ~b_s) | (a_rise & b_s) | (b_fall & a_s) | (b_rise & ~a_s))
                          & ~((a_rise | a_fall) & (b_rise | b_fall)); // RULE_05
            end
            MODE_TWO_PULSE:
            begin
                // Coincident pulses cancel, keeping one step per clock.
                step_up = a_rise & ~b_rise; // RULE_06 RULE_10
                step_dn = b_rise & ~a_rise; // RULE_07 RULE_10
            end
        endcase
    end

    // Index counts only when the channel levels match the chosen phase.
    assign qualified_index = index_enable_in & z_rise & ({a_s, b_s} == index_phase_in); // RULE_08

    ////////////////////////////////////////////////////////////////////////////
    // Position counter.
    logic [`POS_WIDTH-1:0] pos_r;
    logic [`POS_WIDTH-1:0] pos_nxt;

    // The index reload takes precedence over a step in the same cycle.
    always_comb
    begin
        pos_nxt = pos_r;
        if (qualified_index)
            pos_nxt = reload_value_in;    // RULE_09
        else if (step_up)
            pos_nxt = pos_r + `POS_WIDTH'(1); // RULE_02 RULE_06
        else if (step_dn)
            pos_nxt = pos_r - `POS_WIDTH'(1); // RULE_03 RULE_07
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            pos_r <= `POS_RESET;
        else
            pos_r <= pos_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status outputs.
    logic dir_r;
    logic idx_r;

    // Direction holds its last value while the encoder is idle.
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            dir_r <= 1'b0;
        else if (step_dn)
            dir_r <= 1'b1;
        else if (step_up)
            dir_r <= 1'b0;
    end

    // One-cycle marker of an index reload.
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            idx_r <= 1'b0;
        else
            idx_r <= qualified_index;
    end

    assign position_out   = pos_r;
    assign direction_out  = dir_r;
    assign index_seen_out = idx_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    sequence a_rises_b_low;
        $rose(sync2_r[0]) && !sync2_r[1];
    endsequence

    chk_x1_count_up: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_02
        (mode_in == MODE_X1 && !qualified_index) ##0 a_rises_b_low |=> pos_r == $past(pos_r) + 1)
        else $error("X1 forward edge did not count up");

    chk_x1_count_down: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_03
        (mode_in == MODE_X1 && !qualified_index && a_fall && !b_s) |=> pos_r == $past(pos_r) - 1)
        else $error("X1 reverse edge did not count down");

    chk_x1_ignore_b: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_02
        (mode_in == MODE_X1 && !qualified_index && !a_rise && !a_fall) |=> $stable(pos_r))
        else $error("X1 counted without an A edge");

    chk_x2_both_edges: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_04
        (mode_in == MODE_X2 && !qualified_index && a_fall && b_s) |=> pos_r == $past(pos_r) + 1)
        else $error("X2 falling forward edge missed");

    chk_x4_b_edge: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_05
        (mode_in == MODE_X4 && !qualified_index && b_rise && a_s && !a_rise && !a_fall)
        |=> pos_r == $past(pos_r) + 1)
        else $error("X4 B edge did not count");

    chk_two_pulse_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_06
        (mode_in == MODE_TWO_PULSE && !qualified_index && a_rise && !b_rise) |=> pos_r == $past(pos_r) + 1)
        else $error("Two-pulse A did not count up");

    chk_two_pulse_b: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_07
        (mode_in == MODE_TWO_PULSE && !qualified_index && b_rise && !a_rise) |=> pos_r == $past(pos_r) - 1)
        else $error("Two-pulse B did not count down");

    chk_index_reload: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_09
        qualified_index |=> pos_r == $past(reload_value_in) && index_seen_out)
        else $error("Qualified index did not reload position");

    chk_index_phase: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_08
        (z_rise && index_enable_in && {a_s, b_s} != index_phase_in) |=> !index_seen_out)
        else $error("Unqualified index was accepted");

    chk_single_step: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_10
        !qualified_index |=> (pos_r == $past(pos_r)) || (pos_r == $past(pos_r) + 1)
        || (pos_r == $past(pos_r) - 1))
        else $error("More than one step in a clock");

    chk_sync_delay: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_10
        $rose(chan_a_in) ##1 chan_a_in |=> $rose(sync2_r[0]) || sync2_r[0])
        else $error("Channel A synchroniser lag wrong");

    // Reverse motion in double-edge mode: A rising while B is high must count down.
    // Without this the reverse half of the double-edge decode would go unguarded.
    chk_x2_reverse_edge: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_04
        (mode_in == MODE_X2 && !qualified_index && a_rise && b_s) |=> pos_r == $past(pos_r) - 1)
        else $error("X2 rising reverse edge missed");

    // A down step must leave the direction flag showing reverse motion on the next cycle.
    // Software reads the flag to tell which way the shaft last moved.
    chk_dir_reverse: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_01
        step_dn |=> direction_out)
        else $error("Direction did not show reverse motion");

endmodule : encoder_position_counter
`default_nettype wire

// [encoder_model.sv]
// Behavioural encoder that drives channels A, B and the index pin.
`timescale 1ns/1ps
`default_nettype none
module encoder_model
(
    input  wire logic clock_in,   // Paces edges; pins move at its falling edge.
    output var logic  chan_a_out, // Channel A.
    output var logic  chan_b_out, // Channel B.
    output var logic  index_out   // Index pulse.
);
    // Pins start low, so releasing reset shows no edge.
    initial
    begin
        chan_a_out = 1'b0;
        chan_b_out = 1'b0;
        index_out  = 1'b0;
    end
    // One quarter cycle; A leads going forward, B leads going back.
    task automatic quarter(input logic fwd);
        @(negedge clock_in);
        {chan_a_out, chan_b_out} = fwd ? {~chan_b_out, chan_a_out} : {chan_b_out, ~chan_a_out};
        repeat (2) @(negedge clock_in);
    endtask : quarter
    // One pulse on a single channel; each channel stands for one direction.
    task automatic pulse(input logic on_b);
        @(negedge clock_in);
        chan_a_out = ~on_b;
        chan_b_out = on_b;
        repeat (2) @(negedge clock_in);
        chan_a_out = 1'b0;
        chan_b_out = 1'b0;
        repeat (2) @(negedge clock_in);
    endtask : pulse
    // Index pulse while A and B hold still, so its phase is whatever they show.
    task automatic index_pulse;
        @(negedge clock_in);
        index_out = 1'b1;
        repeat (3) @(negedge clock_in);
        index_out = 1'b0;
        repeat (2) @(negedge clock_in);
    endtask : index_pulse
endmodule : encoder_model
`default_nettype wire

// [test_encoder_position_counter.sv]
// Self-checking bench for the encoder position counter.
`timescale 1ns/1ps
`default_nettype none
`include "encoder_position_counter_map.svh"
module test_encoder_position_counter
    import encoder_position_counter_pkg::*;
;
    logic                  clock_in;                  // 10 MHz clock.
    logic                  rst_in;                    // Reset, held at start.
    decode_mode_t          mode_in;                   // Resolution under test.
    logic                  index_enable_in;           // Index reload enable.
    logic [1:0]            index_phase_in;            // Qualifying {A,B}.
    logic [`POS_WIDTH-1:0] reload_value_in;           // Value a qualified index loads.
    logic [`POS_WIDTH-1:0] position_out;
    logic                  chan_a, chan_b, index_pin, direction_out, index_seen_out;
    int                    fails = 0;
    int                    n_compared = 0;
    initial
    begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    encoder_model i_encoder_model (.clock_in(clock_in), .chan_a_out(chan_a), .chan_b_out(chan_b), .index_out(index_pin));
    encoder_position_counter i_encoder_position_counter
    (
        .clock_in(clock_in), .rst_in(rst_in), .chan_a_in(chan_a), .chan_b_in(chan_b), .index_in(index_pin),
        .mode_in(mode_in), .index_enable_in(index_enable_in), .index_phase_in(index_phase_in),
        .reload_value_in(reload_value_in), .position_out(position_out), .direction_out(direction_out),
        .index_seen_out(index_seen_out)
    );
    ////////////////////////////////////////////////////////////
    // Prints the verdict and ends the run; also the early exit when no index load is seen.
    task automatic results;
        if (fails == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    // Four-state compare, so an unknown never passes.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            $display("unexpected at %0t ns: %s is %h, expected %h", $time, what, got, exp);
            fails++;
        end
    endtask : check
    // Sixteen cycles of reset, then position must read zero.
    task automatic reset_dut;
        @(negedge clock_in);
        rst_in = 1'b1;
        repeat (16) @(negedge clock_in);
        rst_in = 1'b0;
        check(position_out, 32'h0, "reset position");
    endtask : reset_dut
    // One cycle forward and two back in each quadrature resolution.
    task automatic quad_modes;
        logic [31:0] k;
        for (int i = 0; i < 3; i++)
        begin
            mode_in = decode_mode_t'(i);
            k = 32'h1 << i;
            reset_dut();
            i_encoder_model.quarter(1'b1);
            check(position_out, 32'h0, "early position");
            @(negedge clock_in);
            check(position_out, 32'h1, "first step");
            repeat (3) i_encoder_model.quarter(1'b1);
            repeat (3) @(negedge clock_in);
            check(position_out, k, "forward count");
            check({31'h0, direction_out}, 32'h0, "forward direction");
            repeat (8) i_encoder_model.quarter(1'b0);
            repeat (3) @(negedge clock_in);
            check(position_out, 32'h0 - k, "reverse count");
            check({31'h0, direction_out}, 32'h1, "reverse direction");
        end
    endtask : quad_modes
    // Channel A pulses count up, channel B pulses count down.
    task automatic two_pulse;
        mode_in = MODE_TWO_PULSE;
        reset_dut();
        repeat (2) i_encoder_model.pulse(1'b0);
        check(position_out, 32'h2, "A pulses");
        i_encoder_model.pulse(1'b1);
        check(position_out, 32'h1, "B pulse");
    endtask : two_pulse
    // A qualified index reloads; wrong phase or disabled leaves the count alone.
    task automatic index_align;
        int n;
        logic seen;
        mode_in = MODE_X4;
        reset_dut();
        index_phase_in = 2'b10;
        index_enable_in = 1'b1;
        i_encoder_model.quarter(1'b1);
        fork
            i_encoder_model.index_pulse();
            for (n = 0; n < 12 && index_seen_out !== 1'b1; n++) @(negedge clock_in);
        join
        if (n == 12)
        begin
            $display("unexpected at %0t ns: no index load", $time);
            fails++;
            results();
        end
        check(position_out, 32'h0000_1234, "index load");
        reload_value_in = 32'h0000_5678;
        for (int j = 0; j < 2; j++)
        begin
            index_phase_in = (j == 0) ? 2'b01 : 2'b10;
            index_enable_in = (j == 0);
            seen = 1'b0;
            fork
                i_encoder_model.index_pulse();
                repeat (8)
                begin
                    @(negedge clock_in);
                    seen = seen | index_seen_out;
                end
            join
            check({31'h0, seen}, 32'h0, "refused marker");
            check(position_out, 32'h0000_1234, "refused index");
        end
    endtask : index_align
    initial
    begin
        rst_in          = 1'b1;
        mode_in         = MODE_X1;
        index_enable_in = 1'b0;
        index_phase_in  = 2'h0;
        reload_value_in = 32'h0000_1234;
        quad_modes();
        two_pulse();
        index_align();
        results();
    end
endmodule : test_encoder_position_counter
`default_nettype wire
